// file: spi_status_defines.vh
// constants for the serial flash status and protection command block
`ifndef SPI_STATUS_DEFINES_VH
`define SPI_STATUS_DEFINES_VH
`define OP_STATUS_READ      8'h05
`define OP_WRITE_ENABLE     8'h06
`define OP_WRITE_DISABLE    8'h04
`define OP_STATUS_WRITE_ARM 8'h50
`define OP_STATUS_WRITE     8'h01
`define OP_ID_READ_A        8'h90
`define OP_ID_READ_B        8'hab
// status byte field positions
`define SR_BUSY_BIT         0
`define SR_WEL_BIT          1
`define SR_BPLO_BIT         2
`define SR_BPHI_BIT         3
`define SR_AAI_BIT          6
`define SR_LOCK_BIT         7
`define SR_RESET_VAL        8'h00
// identification bytes, values arbitrary
`define ID_MAKER_VAL        8'h5a
`define ID_PART_VAL         8'h3c
`define ADDR_BITS           5'd24
`endif

// file: spi_flash_status_protect_cmds.v
// serial flash command handling for status, write enable latch and identification
`timescale 1ns/1ps
`default_nettype none
`include "spi_status_defines.vh"
// Rules for this block and its host
// R1: status read is answered at any time, even while busy.
// R2: status byte repeats on every further eight clocks until select rises.
// R3: host holds select low from status read opcode until data read.
// R4: host should poll busy before new commands during a write.
// R5: write enable command sets the write enable latch.
// R6: host issues write enable before every program or erase.
// R7: write enable acts on the rising edge of select after the opcode.
// R8: write disable clears write enable latch and auto increment flag.
// R9: write disable acts only when select rises after the opcode.
// R10: status write arm holds only for the very next instruction.
// R11: status write arm is executed on the select rising edge.
// R12: accepted status write changes only both protect level bits and lock bit.
// R13: status write ignored while protect pin low and lock bit set.
// R14: with protect pin low, lock bit may only go from 0 to 1.
// R15: with protect pin high, lock and level bits change freely.
// R16: permission uses lock bit and pin level just before select rises.
// R17: one permitted status write may set lock and change levels together.
// R18: status write commits new bits on the select rising edge.
// R19: identification read starts with either of two opcodes plus 24-bit address.
// R20: address zero gives maker code, address one gives part code.
// R21: identification output alternates between both codes until select rises.
// R22: write disable opcode is 04h and ends auto increment programming.
// R23: address bit zero selects maker or part code in identification.
// R24: input sampled on rising clock, msb first, output on falling clock.
// R25: opcodes 05h, 06h, 50h and 01h, one byte after select falls.
// R26: busy reads 1 while an internal program or erase runs.

// timing notes for users of this block:
// - select, clock and data are seen three to four system clocks late, so the
//   serial clock high and low phases must each last at least four system clocks
// - a command commits four to five system clocks after select rises; the host
//   should keep select high long enough before the next frame
// - output bits change four to five system clocks after a sampled clock fall,
//   which leaves the host a full low phase to take them on the next rise
// - the protect pin passes the same three-flop sampler, so a pin change only
//   affects a status write whose select rise comes at least one clock later
// - one-byte commands with extra clocks are ignored past the opcode, so a
//   host that pads a frame does not re-decode its filler bits
module spi_flash_status_protect_cmds (
    input  wire       ref_clk,
    input  wire       resetn,
    input  wire       chip_select_n,
    input  wire       serial_clk,
    input  wire       serial_in,
    input  wire       write_protect_n,
    input  wire       internal_busy,
    input  wire       auto_increment_set,
    output reg        serial_out,
    output reg        serial_out_en,
    output reg        write_enable_latch,
    output reg        auto_increment_program_flag,
    output reg        block_protect_level_lo,
    output reg        block_protect_level_hi,
    output reg        protect_lock_bit,
    output reg        busy
);
    // frame states: opcode byte, id address, reply shifting, status data byte
    localparam ST_OPCODE = 2'd0;
    localparam ST_ADDR   = 2'd1;
    localparam ST_OUT    = 2'd2;
    localparam ST_DATA   = 2'd3;

    // reset release through two flops
    reg [1:0] rst_sync;
    wire      rst_n = rst_sync[1];
    always @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            rst_sync <= 2'b00;
        end else begin
            rst_sync <= {rst_sync[0], 1'b1};
        end
    end

    // stages two and three agree, so the sampled level has settled
    function settled;
        input [2:0] s;
        begin
            settled = (s[1] == s[2]);
        end
    endfunction

    // three-flop samplers; a change counts when stages two and three agree
    // the filtered copies are the only levels the edge logic trusts
    reg [2:0] cs_s, sck_s, si_s, wp_s;
    reg       cs_q, sck_q, wp_q;
    always @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            cs_s  <= 3'b111;
            sck_s <= 3'b000;
            si_s  <= 3'b000;
            wp_s  <= 3'b111;
            cs_q  <= 1'b1;
            sck_q <= 1'b0;
            wp_q  <= 1'b1;
        end else begin
            cs_s  <= {cs_s[1:0], chip_select_n};
            sck_s <= {sck_s[1:0], serial_clk};
            si_s  <= {si_s[1:0], serial_in};
            wp_s  <= {wp_s[1:0], write_protect_n};
            if (settled(cs_s)) cs_q <= cs_s[2];
            if (settled(sck_s)) sck_q <= sck_s[2];
            if (settled(wp_s)) wp_q <= wp_s[2];
        end
    end

    wire cs_fall  = cs_q & settled(cs_s) & ~cs_s[2];
    wire cs_rise  = ~cs_q & settled(cs_s) & cs_s[2];
    wire sck_rise = ~cs_q & ~sck_q & settled(sck_s) & sck_s[2]; // R24
    wire sck_fall = ~cs_q & sck_q & settled(sck_s) & ~sck_s[2]; // R24

    reg [1:0]  state;
    reg [4:0]  bit_cnt;
    reg [7:0]  opcode;
    reg [7:0]  shift_in;
    reg [7:0]  shift_out;
    reg        id_sel;
    reg        arm;
    reg [7:0]  wr_data;
    reg        data_done;
    reg [7:0]  status_byte;

    // status byte assembled from the field positions; unused bits read as zero
    always @* begin
        status_byte                 = `SR_RESET_VAL;
        status_byte[`SR_BUSY_BIT]   = busy;
        status_byte[`SR_WEL_BIT]    = write_enable_latch;
        status_byte[`SR_BPLO_BIT]   = block_protect_level_lo;
        status_byte[`SR_BPHI_BIT]   = block_protect_level_hi;
        status_byte[`SR_AAI_BIT]    = auto_increment_program_flag;
        status_byte[`SR_LOCK_BIT]   = protect_lock_bit;
    end
    wire [7:0] next_shift_in = {shift_in[6:0], si_s[2]};

    // pick identification byte from the address low bit
    function [7:0] id_byte;
        input sel;
        begin
            id_byte = sel ? `ID_PART_VAL : `ID_MAKER_VAL; // R20 R23
        end
    endfunction

    // busy follows the internal timer every cycle so status read sees it live
    // one cycle of lag is far below a serial bit time, so no poll misses it
    always @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            busy <= 1'b0;
        end else begin
            busy <= internal_busy; // R26 R1
        end
    end

    // serial front end: opcode, address, data byte and output shifting
    // a deselected frame forces the opcode state so a cut frame leaves no residue
    always @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            state         <= ST_OPCODE;
            bit_cnt       <= 5'd0;
            opcode        <= 8'h00;
            shift_in      <= 8'h00;
            shift_out     <= 8'h00;
            id_sel        <= 1'b0;
            wr_data       <= 8'h00;
            data_done     <= 1'b0;
            serial_out    <= 1'b0;
            serial_out_en <= 1'b0;
        end else if (cs_fall || cs_q) begin
            state         <= ST_OPCODE;
            bit_cnt       <= 5'd0;
            data_done     <= 1'b0;
            serial_out_en <= 1'b0;
        end else if (sck_rise) begin
            shift_in <= next_shift_in; // R24
            case (state)
                ST_OPCODE: begin
                    if (bit_cnt == 5'd7) begin
                        opcode  <= next_shift_in; // R25
                        bit_cnt <= 5'd0;
                        if (next_shift_in == `OP_STATUS_READ) begin
                            state     <= ST_OUT; // R1
                            shift_out <= status_byte;
                        end else if (next_shift_in == `OP_ID_READ_A ||
                                     next_shift_in == `OP_ID_READ_B) begin
                            state <= ST_ADDR; // R19
                        end else if (next_shift_in == `OP_STATUS_WRITE) begin
                            state <= ST_DATA;
                        end else begin
                            // one-byte commands park in the data state with nothing
                            // left to take, so padding clocks are never re-decoded
                            state     <= ST_DATA;
                            data_done <= 1'b1;
                        end
                    end else begin
                        bit_cnt <= bit_cnt + 5'd1;
                    end
                end
                ST_ADDR: begin
                    if (bit_cnt == `ADDR_BITS - 5'd1) begin
                        id_sel    <= si_s[2]; // R23
                        shift_out <= id_byte(si_s[2]);
                        bit_cnt   <= 5'd0;
                        state     <= ST_OUT;
                    end else begin
                        bit_cnt <= bit_cnt + 5'd1;
                    end
                end
                ST_DATA: begin
                    // only the first data byte counts; extra clocks are ignored
                    if (!data_done) begin
                        if (bit_cnt == 5'd7) begin
                            wr_data   <= next_shift_in;
                            data_done <= 1'b1;
                            bit_cnt   <= 5'd0;
                        end else begin
                            bit_cnt <= bit_cnt + 5'd1;
                        end
                    end
                end
                default: begin
                    state <= ST_OUT;
                end
            endcase
        // reply bits move on the falling clock so the host takes them on the rise
        end else if (sck_fall && state == ST_OUT) begin
            serial_out_en <= 1'b1;
            serial_out    <= shift_out[7]; // R24
            if (bit_cnt == 5'd7) begin
                bit_cnt <= 5'd0;
                if (opcode == `OP_STATUS_READ) begin
                    shift_out <= status_byte; // R2
                end else begin
                    id_sel    <= ~id_sel; // R21
                    shift_out <= id_byte(~id_sel);
                end
            end else begin
                bit_cnt   <= bit_cnt + 5'd1;
                shift_out <= {shift_out[6:0], 1'b0};
            end
        end
    end

    // commands act on the select rising edge; pin and lock sampled just before it
    wire wp_high  = wp_q;
    wire permit   = ~protect_lock_bit | wp_high; // R13 R16
    // frames shorter than one opcode byte must not commit a stale opcode
    reg  frame_has_op;
    always @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            frame_has_op <= 1'b0;
        end else if (cs_fall) begin
            frame_has_op <= 1'b0;
        end else if (sck_rise && state == ST_OPCODE && bit_cnt == 5'd7) begin
            frame_has_op <= 1'b1;
        end
    end

    // status bits and the one-shot arming for status write
    // the arming is judged before it is overwritten, so only the next frame sees it
    always @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            write_enable_latch          <= 1'b0;
            auto_increment_program_flag <= 1'b0;
            block_protect_level_lo      <= 1'b0;
            block_protect_level_hi      <= 1'b0;
            protect_lock_bit            <= 1'b0;
            arm                         <= 1'b0;
        end else begin
            if (auto_increment_set) begin
                auto_increment_program_flag <= 1'b1;
            end
            if (cs_rise && frame_has_op) begin
                // any instruction other than status write arm discards the arming
                arm <= (opcode == `OP_STATUS_WRITE_ARM); // R10 R11
                case (opcode)
                    `OP_WRITE_ENABLE: begin
                        write_enable_latch <= 1'b1; // R5 R7
                    end
                    `OP_WRITE_DISABLE: begin
                        write_enable_latch          <= 1'b0; // R8 R9 R22
                        auto_increment_program_flag <= 1'b0; // R8 R22
                    end
                    `OP_STATUS_WRITE: begin
                        if (arm && data_done && permit) begin // R10 R13 R16
                            block_protect_level_lo <= wr_data[`SR_BPLO_BIT]; // R12 R15 R17 R18
                            block_protect_level_hi <= wr_data[`SR_BPHI_BIT]; // R12 R15 R17
                            // pin low: lock may only rise (R14)
                            protect_lock_bit <= wr_data[`SR_LOCK_BIT] |
                                                (protect_lock_bit & ~wp_high); // R14 R15
                        end
                    end
                    default: begin
                        // other opcodes only set or drop the arming above
                    end
                endcase
            end
        end
    end
endmodule // spi_flash_status_protect_cmds
`default_nettype wire

// file: spi_status_properties.sv
// port assertions for the status and protection command block
`timescale 1ns/1ps
`default_nettype none
module spi_status_properties (
    input wire logic ref_clk,
    input wire logic resetn,
    input wire logic chip_select_n,
    input wire logic write_protect_n,
    input wire logic internal_busy,
    input wire logic serial_out_en,
    input wire logic write_enable_latch,
    input wire logic auto_increment_program_flag,
    input wire logic block_protect_level_lo,
    input wire logic block_protect_level_hi,
    input wire logic protect_lock_bit,
    input wire logic busy
);
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!resetn);
    // select low this long means no commit can still be in flight
    sequence s_sel_long;
        !chip_select_n [*8];
    endsequence
    // lock set with the pin low, settled past the pin sampler
    sequence s_locked;
        (protect_lock_bit && !write_protect_n) [*6];
    endsequence
    a_oe_idle_off: assert property (chip_select_n [*6] |-> !serial_out_en)
        else $error("output driven while deselected");
    a_flags_sel_stable: assert property (s_sel_long |=> $stable({write_enable_latch,
        block_protect_level_lo, block_protect_level_hi, protect_lock_bit}))
        else $error("flag moved inside a frame");
    a_busy_follow: assert property ($stable(internal_busy) [*4] |-> busy == internal_busy)
        else $error("busy does not follow the program timer");
    a_lock_held: assert property (s_locked |=> protect_lock_bit)
        else $error("lock cleared while pin low");
    a_level_held: assert property (
        s_locked |=> $stable({block_protect_level_hi, block_protect_level_lo}))
        else $error("protect level changed while locked");
    a_wen_rise_deselect: assert property (
        $rose(write_enable_latch) |-> chip_select_n && $past(chip_select_n, 3))
        else $error("write enable set before select rise");
    a_wen_fall_deselect: assert property (
        $fell(write_enable_latch) |-> chip_select_n && $past(chip_select_n, 3))
        else $error("write enable cleared before select rise");
    a_auto_fall_deselect: assert property ($fell(auto_increment_program_flag) |-> chip_select_n)
        else $error("auto flag cleared inside a frame");
    a_lock_commit_edge: assert property (!$stable(protect_lock_bit) |-> chip_select_n)
        else $error("lock changed inside a frame");
    a_oe_frame_only: assert property ($rose(serial_out_en) |-> !chip_select_n)
        else $error("output enabled outside a frame");
endmodule // spi_status_properties
bind spi_flash_status_protect_cmds spi_status_properties u_props (.ref_clk, .resetn,
    .chip_select_n, .write_protect_n, .internal_busy, .serial_out_en, .write_enable_latch,
    .auto_increment_program_flag, .block_protect_level_lo, .block_protect_level_hi,
    .protect_lock_bit, .busy);
`default_nettype wire

// file: spi_host_model.sv
// spi host model driving select, clock and data toward the flash block
`timescale 1ns/1ps
`default_nettype none
module spi_host_model (
    input  wire logic ref_clk,
    input  wire logic serial_out,
    output var  logic chip_select_n,
    output var  logic serial_clk,
    output var  logic serial_in
);
    initial begin
        chip_select_n = 1'b1;
        serial_clk = 1'b0; // clock parks low between frames
        serial_in = 1'b0;
    end
    // all changes land just after a system clock edge
    task automatic tick(input int n);
        repeat (n) @(posedge ref_clk);
        #1;
    endtask
    // one whole frame, msb first; select rise executes the command
    task automatic xfer(input logic [47:0] tx, input int n, output logic [47:0] rx);
        rx = '0;
        chip_select_n = 1'b0;
        for (int i = 0; i < n; i++) begin
            serial_in = tx[47-i];
            tick(8);
            serial_clk = 1'b1;
            rx = {rx[46:0], serial_out};
            tick(8);
            serial_clk = 1'b0;
        end
        tick(8);
        chip_select_n = 1'b1;
        serial_in = ~serial_in; // released line, stale value not kept
        tick(14); // gap over 100 ns, lets the commit land
    endtask
endmodule // spi_host_model
`default_nettype wire

// file: tb.sv
// self-checking bench for the status and protection command block
`timescale 1ns/1ps
`default_nettype none
`include "spi_status_defines.vh"
module tb;
    logic ref_clk, resetn, chip_select_n, serial_clk, serial_in, serial_out, serial_out_en;
    logic write_protect_n, internal_busy, auto_increment_set, busy;
    logic write_enable_latch, auto_increment_program_flag, protect_lock_bit;
    logic block_protect_level_lo, block_protect_level_hi;
    logic [7:0]  status_pins;
    logic [47:0] rx;
    int          fail_count, check_count;
    assign status_pins = {protect_lock_bit, auto_increment_program_flag, 2'b00,
        block_protect_level_hi, block_protect_level_lo, write_enable_latch, busy};
    spi_flash_status_protect_cmds dut (.ref_clk, .resetn, .chip_select_n, .serial_clk,
        .serial_in, .write_protect_n, .internal_busy, .auto_increment_set, .serial_out,
        .serial_out_en, .write_enable_latch, .auto_increment_program_flag,
        .block_protect_level_lo, .block_protect_level_hi, .protect_lock_bit, .busy);
    spi_host_model host (.ref_clk, .serial_out, .chip_select_n, .serial_clk, .serial_in);
    initial begin
        ref_clk = 1'b0;
        forever #5 ref_clk = ~ref_clk;
    end
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        check_count++;
        if (seen !== exp) begin
            fail_count++;
            $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic cmd(input logic [7:0] op);
        host.xfer({op, 40'h0}, 8, rx);
    endtask
    // status byte read twice in one frame, then compared with the pins
    task automatic status(input logic [7:0] exp);
        host.xfer({`OP_STATUS_READ, 40'h0}, 24, rx);
        check(rx[15:0], {exp, exp});
        check({8'h00, status_pins}, {8'h00, exp});
    endtask
    task automatic swrite(input logic [7:0] d);
        cmd(`OP_STATUS_WRITE_ARM);
        host.xfer({`OP_STATUS_WRITE, d, 32'h0}, 16, rx);
    endtask
    task automatic results;
        if (fail_count == 0 && check_count > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    initial begin
        resetn = 1'b0;
        write_protect_n = 1'b0;
        internal_busy = 1'b0;
        auto_increment_set = 1'b0;
        fail_count = 0;
        check_count = 0;
        host.tick(2);
        resetn = 1'b1;
        host.tick(8);
        status(8'h00);
        cmd(`OP_WRITE_ENABLE);
        status(8'h02);
        internal_busy = 1'b1;
        host.tick(4);
        status(8'h03);
        internal_busy = 1'b0;
        auto_increment_set = 1'b1;
        host.tick(1);
        auto_increment_set = 1'b0;
        check({15'h0000, auto_increment_program_flag}, 16'h0001);
        cmd(`OP_WRITE_DISABLE);
        status(8'h00);
        // an intervening command throws the arming away
        cmd(`OP_STATUS_WRITE_ARM);
        cmd(`OP_WRITE_ENABLE);
        host.xfer({`OP_STATUS_WRITE, 8'h8c, 32'h0}, 16, rx);
        status(8'h02);
        swrite(8'h8c);
        status(8'h8e);
        swrite(8'h00);
        status(8'h8e);
        write_protect_n = 1'b1;
        host.tick(4);
        swrite(8'h77);
        status(8'h06);
        host.xfer({`OP_ID_READ_A, 24'h0, 16'h0}, 48, rx);
        check(rx[15:0], {`ID_MAKER_VAL, `ID_PART_VAL});
        host.xfer({`OP_ID_READ_B, 24'h1, 16'h0}, 48, rx);
        check(rx[15:0], {`ID_PART_VAL, `ID_MAKER_VAL});
        results();
    end
    // hang guard, about seven times the normal run length
    initial begin
        #500000;
        fail_count++;
        results();
    end
endmodule // tb
`default_nettype wire
